// >>> hdl/ioa_defines.svh
/*
  Offsets, field positions, reset values and command codes of the
  io read / accumulator / compare command interpreter.
  Assumes a byte-addressed APB slave with 32-bit words.
*/
`ifndef IOA_DEFINES_SVH
`define IOA_DEFINES_SVH

`define IOA_OFF_CTRL 8'h00
`define IOA_OFF_CMD 8'h04
`define IOA_OFF_VALUE 8'h08
`define IOA_OFF_STATUS 8'h0c
`define IOA_OFF_RPL_HDR 8'h10
`define IOA_OFF_RPL_VAL 8'h14
`define IOA_OFF_RPL_SUM 8'h18
`define IOA_OFF_ACC 8'h1c

`define IOA_CTRL_GO 0
`define IOA_CTRL_STANDALONE 1
`define IOA_STAT_DONE 0
`define IOA_STAT_BUSY 1
`define IOA_STAT_FLAGS 8

`define IOA_HOST_ADDR_RST 8'h02
`define IOA_MODULE_ADDR_RST 8'h01

`define IOA_OP_SET_OUT 8'h0e
`define IOA_OP_READ_IO 8'h0f
`define IOA_OP_ACCUMULATE_CMD_A 8'h13
`define IOA_OP_COMP 8'h14
`define IOA_OP_JUMP 8'h15

`define IOA_ST_OK 8'h64
`define IOA_ST_BAD_SUM 8'h01
`define IOA_ST_BAD_CMD 8'h02
`define IOA_ST_BAD_TYPE 8'h03
`define IOA_ST_BAD_VAL 8'h04

`define IOA_BANK_DIG 8'h00
`define IOA_BANK_ANA 8'h01
`define IOA_BANK_OUT 8'h02
`define IOA_PORT_ALL 8'hff
`define IOA_PORT_VOLT 8'h08
`define IOA_PORT_TEMP 8'h09

`endif

// >>> hdl/ioa_pkg.sv
/*
  Types of the command interpreter: sequencing states, calculate
  operations and jump conditions.
  Assumes nothing of its surroundings.
*/
package ioa_pkg;

  typedef enum logic [1:0]
  {
    IOA_IDLE = 2'b00,
    IOA_EXEC = 2'b01,
    IOA_REPLY = 2'b11
  } ioa_state_e;

  typedef enum logic [7:0]
  {
    IOA_ADD = 8'h00,
    IOA_SUB = 8'h01,
    IOA_MUL = 8'h02,
    IOA_DIV = 8'h03,
    IOA_MOD = 8'h04,
    IOA_AND = 8'h05,
    IOA_OR = 8'h06,
    IOA_XOR = 8'h07,
    IOA_NOT = 8'h08,
    IOA_LOAD = 8'h09
  } ioa_accumulate_cmd_a_e;

  typedef enum logic [7:0]
  {
    IOA_JZE = 8'h00,
    IOA_JNZ = 8'h01,
    IOA_JEQ = 8'h02,
    IOA_JNE = 8'h03,
    IOA_JGT = 8'h04,
    IOA_JGE = 8'h05,
    IOA_JLT = 8'h06,
    IOA_JLE = 8'h07
  } ioa_cond_e;

endpackage

// >>> hdl/ioa_core.sv
/*
  Command interpreter for the read-io, calculate, compare, set-output
  and conditional-jump commands, reached over APB.
  Assumes pins input_line_* are asynchronous; analog, voltage and
  temperature words come from converters on the same clock.
*/
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ioa_defines.svh"

// Notes on behaviour
// - Bank 0 ports 0-2 return input bit
// - Digital and analog reads are independent
// - Port 255 bank 0 loads input vector
// - Bank 1 port 0 returns analog value
// - Bank 1 port 8 returns supply tenths
// - Bank 1 port 9 returns temperature
// - Bank 2 port 0 returns driven output state
// - Calculate types 0-4 arithmetic operations
// - Calculate types 5-7 bitwise logic
// - Type 8 inverts, type 9 loads
// - Calculate result written to accumulator
// - Calculate answers status 100
// - Opcode 20 compares with value field
// - Compare leaves accumulator unchanged
// - Compare updates zero, equal, order flags
// - Analog 12-bit unsigned, digital 0/1
// - Read-io to accumulator only standalone or bank 0 port 255
// - Jump conditions use last compare flags
module ioa_core #(
  parameter int ADC_W = 12,
  parameter int SUP_W = 16,
  parameter int TEMP_W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic input_line_zero,
  input wire logic input_line_one,
  input wire logic input_line_two,
  input wire logic [ADC_W-1:0] analog_line_zero,
  input wire logic [SUP_W-1:0] supply_tenths,
  input wire logic signed [TEMP_W-1:0] temperature_c,
  output logic output_line_zero
);

  function automatic logic [7:0] byte_sum(input logic [31:0] w);
    byte_sum = w[31:24] + w[23:16] + w[15:8] + w[7:0];
  endfunction

  logic [2:0] in_meta_ff;
  logic [2:0] in_sync_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic standalone_ff;
  logic [7:0] host_addr_ff;
  logic [7:0] module_addr_ff;
  logic [31:0] cmd_ff;
  logic [31:0] value_ff;
  logic done_ff;
  ioa_pkg::ioa_state_e state_ff;
  logic signed [31:0] acc_ff;
  logic flag_zero_ff;
  logic flag_eq_ff;
  logic flag_gt_ff;
  logic flag_lt_ff;
  logic out_ff;
  logic [7:0] rpl_status_ff;
  logic [7:0] rpl_op_ff;
  logic [31:0] rpl_val_ff;
  logic [7:0] rpl_sum_ff;

  logic acc_wr;
  logic go_wr;
  logic [7:0] cmd_op;
  logic [7:0] cmd_type;
  logic [7:0] cmd_bank;
  logic [7:0] cmd_sum;
  logic sum_ok;
  logic [7:0] nxt_status;
  logic [31:0] nxt_val;
  logic signed [31:0] nxt_acc;
  logic nxt_acc_en;
  logic nxt_flags_en;
  logic nxt_out_en;
  logic cond_met;

  assign acc_wr = psel && penable && pready_ff && pwrite;
  assign go_wr = acc_wr && (paddr == `IOA_OFF_CTRL) &&
                 pwdata[`IOA_CTRL_GO] && (state_ff == ioa_pkg::IOA_IDLE);
  assign cmd_op = cmd_ff[7:0];
  assign cmd_type = cmd_ff[15:8];
  assign cmd_bank = cmd_ff[23:16];
  assign cmd_sum = cmd_ff[31:24];
  assign sum_ok = (module_addr_ff + cmd_op + cmd_type + cmd_bank +
                   byte_sum(value_ff)) == cmd_sum;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign output_line_zero = out_ff;

  // Pins pass two flops; analog words are read directly
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      in_meta_ff <= 3'h0;
      in_sync_ff <= 3'h0;
    end
    else
    begin
      in_meta_ff <= {input_line_two, input_line_one, input_line_zero};
      in_sync_ff <= in_meta_ff;
    end
  end

  // One wait state on every access
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end
    else
    begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
      if (psel && penable && !pready_ff)
      begin
        case (paddr)
          `IOA_OFF_CTRL:
            prdata_ff <= {8'h00, host_addr_ff, module_addr_ff, 6'h00,
                          standalone_ff, 1'b0};
          `IOA_OFF_CMD: prdata_ff <= cmd_ff;
          `IOA_OFF_VALUE: prdata_ff <= value_ff;
          `IOA_OFF_STATUS:
            prdata_ff <= {20'h0, flag_lt_ff, flag_gt_ff, flag_eq_ff,
                          flag_zero_ff, 6'h00,
                          state_ff != ioa_pkg::IOA_IDLE, done_ff};
          `IOA_OFF_RPL_HDR:
            prdata_ff <= {host_addr_ff, module_addr_ff, rpl_status_ff,
                          rpl_op_ff};
          `IOA_OFF_RPL_VAL: prdata_ff <= rpl_val_ff;
          `IOA_OFF_RPL_SUM: prdata_ff <= {24'h0, rpl_sum_ff};
          `IOA_OFF_ACC: prdata_ff <= acc_ff;
          default: pslverr_ff <= 1'b1;
        endcase
      end
    end
  end

  // Software-written configuration and command frame
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      standalone_ff <= 1'b0;
      host_addr_ff <= `IOA_HOST_ADDR_RST;
      module_addr_ff <= `IOA_MODULE_ADDR_RST;
      cmd_ff <= 32'h0;
      value_ff <= 32'h0;
    end
    else if (acc_wr)
    begin
      case (paddr)
        `IOA_OFF_CTRL:
        begin
          standalone_ff <= pwdata[`IOA_CTRL_STANDALONE];
          module_addr_ff <= pwdata[15:8];
          host_addr_ff <= pwdata[23:16];
        end
        `IOA_OFF_CMD: cmd_ff <= pwdata;
        `IOA_OFF_VALUE: value_ff <= pwdata;
        default: ;
      endcase
    end
  end

  // Sequencer: accept, execute, build reply
  always_ff @(posedge clk)
  begin
    if (!resetn)
      state_ff <= ioa_pkg::IOA_IDLE;
    else
    begin
      case (state_ff)
        ioa_pkg::IOA_IDLE:
          if (go_wr)
            state_ff <= ioa_pkg::IOA_EXEC;
        ioa_pkg::IOA_EXEC: state_ff <= ioa_pkg::IOA_REPLY;
        ioa_pkg::IOA_REPLY: state_ff <= ioa_pkg::IOA_IDLE;
        default: state_ff <= ioa_pkg::IOA_IDLE;
      endcase
    end
  end

  // Done is set at reply end; set beats a write-one clear
  always_ff @(posedge clk)
  begin
    if (!resetn)
      done_ff <= 1'b0;
    else if (state_ff == ioa_pkg::IOA_REPLY)
      done_ff <= 1'b1;
    else if (acc_wr && paddr == `IOA_OFF_STATUS && pwdata[`IOA_STAT_DONE])
      done_ff <= 1'b0;
  end

  always_comb
  begin
    case (ioa_pkg::ioa_cond_e'(cmd_type))
      ioa_pkg::IOA_JZE: cond_met = flag_zero_ff;
      ioa_pkg::IOA_JNZ: cond_met = !flag_zero_ff;
      ioa_pkg::IOA_JEQ: cond_met = flag_eq_ff;
      ioa_pkg::IOA_JNE: cond_met = !flag_eq_ff;
      ioa_pkg::IOA_JGT: cond_met = flag_gt_ff;
      ioa_pkg::IOA_JGE: cond_met = flag_gt_ff || flag_eq_ff;
      ioa_pkg::IOA_JLT: cond_met = flag_lt_ff;
      ioa_pkg::IOA_JLE: cond_met = flag_lt_ff || flag_eq_ff;
      default: cond_met = 1'b0;
    endcase
  end

  // Command execution
  always_comb
  begin
    nxt_status = `IOA_ST_OK;
    nxt_val = 32'h0;
    nxt_acc = acc_ff;
    nxt_acc_en = 1'b0;
    nxt_flags_en = 1'b0;
    nxt_out_en = 1'b0;
    if (!sum_ok)
      nxt_status = `IOA_ST_BAD_SUM;
    else
    begin
      case (cmd_op)
        `IOA_OP_READ_IO:
        begin
          case (cmd_bank)
            `IOA_BANK_DIG:
              if (cmd_type == `IOA_PORT_ALL)
              begin
                nxt_val = {29'h0, in_sync_ff};
                nxt_acc_en = 1'b1;
              end
              else if (cmd_type < 8'h03)
                nxt_val = {31'h0, in_sync_ff[cmd_type[1:0]]};
              else
                nxt_status = `IOA_ST_BAD_TYPE;
            `IOA_BANK_ANA:
              if (cmd_type == 8'h00)
                nxt_val = {{(32-ADC_W){1'b0}}, analog_line_zero};
              else if (cmd_type == `IOA_PORT_VOLT)
                nxt_val = {{(32-SUP_W){1'b0}}, supply_tenths};
              else if (cmd_type == `IOA_PORT_TEMP)
                nxt_val = 32'(temperature_c);
              else
                nxt_status = `IOA_ST_BAD_TYPE;
            `IOA_BANK_OUT:
              if (cmd_type == 8'h00)
                nxt_val = {31'h0, out_ff};
              else
                nxt_status = `IOA_ST_BAD_TYPE;
            default: nxt_status = `IOA_ST_BAD_VAL;
          endcase
          nxt_acc = nxt_val;
          if (standalone_ff && nxt_status == `IOA_ST_OK)
            nxt_acc_en = 1'b1;
          if (nxt_status != `IOA_ST_OK)
            nxt_acc_en = 1'b0;
        end
        `IOA_OP_ACCUMULATE_CMD_A:
        begin
          nxt_acc_en = 1'b1;
          nxt_val = value_ff;
          case (ioa_pkg::ioa_accumulate_cmd_a_e'(cmd_type))
            ioa_pkg::IOA_ADD: nxt_acc = acc_ff + $signed(value_ff);
            ioa_pkg::IOA_SUB: nxt_acc = acc_ff - $signed(value_ff);
            ioa_pkg::IOA_MUL: nxt_acc = acc_ff * $signed(value_ff);
            ioa_pkg::IOA_DIV, ioa_pkg::IOA_MOD:
              if (value_ff == 32'h0)
              begin
                nxt_status = `IOA_ST_BAD_VAL;
                nxt_acc_en = 1'b0;
              end
              else if (cmd_type == 8'h03)
                nxt_acc = acc_ff / $signed(value_ff);
              else
                nxt_acc = acc_ff % $signed(value_ff);
            ioa_pkg::IOA_AND: nxt_acc = acc_ff & value_ff;
            ioa_pkg::IOA_OR: nxt_acc = acc_ff | value_ff;
            ioa_pkg::IOA_XOR: nxt_acc = acc_ff ^ value_ff;
            ioa_pkg::IOA_NOT: nxt_acc = ~acc_ff;
            ioa_pkg::IOA_LOAD: nxt_acc = value_ff;
            default:
            begin
              nxt_status = `IOA_ST_BAD_TYPE;
              nxt_acc_en = 1'b0;
            end
          endcase
        end
        `IOA_OP_COMP:
        begin
          nxt_flags_en = 1'b1;
          nxt_val = value_ff;
        end
        `IOA_OP_JUMP:
          if (cmd_type < 8'h08)
            nxt_val = {31'h0, cond_met};
          else
            nxt_status = `IOA_ST_BAD_TYPE;
        `IOA_OP_SET_OUT:
          if (cmd_bank == `IOA_BANK_OUT && cmd_type == 8'h00)
            nxt_out_en = 1'b1;
          else
            nxt_status = `IOA_ST_BAD_TYPE;
        default: nxt_status = `IOA_ST_BAD_CMD;
      endcase
    end
  end

  // Accumulator, flags and output change only in the execute cycle
  always_ff @(posedge clk)
  begin
    if (!resetn)
      acc_ff <= 32'sh0;
    else if (state_ff == ioa_pkg::IOA_EXEC && nxt_acc_en)
      acc_ff <= nxt_acc;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      flag_zero_ff <= 1'b0;
      flag_eq_ff <= 1'b0;
      flag_gt_ff <= 1'b0;
      flag_lt_ff <= 1'b0;
    end
    else if (state_ff == ioa_pkg::IOA_EXEC && nxt_flags_en)
    begin
      flag_zero_ff <= (acc_ff - $signed(value_ff)) == 32'sh0;
      flag_eq_ff <= acc_ff == $signed(value_ff);
      flag_gt_ff <= acc_ff > $signed(value_ff);
      flag_lt_ff <= acc_ff < $signed(value_ff);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      out_ff <= 1'b0;
    else if (state_ff == ioa_pkg::IOA_EXEC && nxt_out_en)
      out_ff <= value_ff[0];
  end

  // Reply fields, checksum formed one cycle after execution
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rpl_status_ff <= 8'h00;
      rpl_op_ff <= 8'h00;
      rpl_val_ff <= 32'h0;
      rpl_sum_ff <= 8'h00;
    end
    else if (state_ff == ioa_pkg::IOA_EXEC)
    begin
      rpl_status_ff <= nxt_status;
      rpl_op_ff <= cmd_op;
      rpl_val_ff <= nxt_val;
    end
    else if (state_ff == ioa_pkg::IOA_REPLY)
      rpl_sum_ff <= host_addr_ff + module_addr_ff + rpl_status_ff +
                    rpl_op_ff + byte_sum(rpl_val_ff);
  end

endmodule

`default_nettype wire

// >>> testbench/ioa_pin_model.sv
/*
  Pin-side model: digital input lines and converter words.
  Assumes the bench picks the digital pattern.
*/
`timescale 1ns/10ps
`default_nettype none
module ioa_pin_model #(
  parameter logic [11:0] ANA = 12'h12e,
  parameter logic [15:0] SUP = 16'h00f0,
  parameter logic [15:0] TMP = 16'hfffb
) (
  input wire logic [2:0] pattern,
  output logic input_line_zero,
  output logic input_line_one,
  output logic input_line_two,
  output logic [11:0] analog_line_zero,
  output logic [15:0] supply_tenths,
  output logic [15:0] temperature_c
);
  // Digital line zero follows pattern; analog line zero is the fixed ANA word
  assign input_line_zero = pattern[0];
  assign input_line_one = pattern[1];
  assign input_line_two = pattern[2];
  assign analog_line_zero = ANA;
  assign supply_tenths = SUP;
  assign temperature_c = TMP;
endmodule
`default_nettype wire

// >>> testbench/ioa_core_sva.sv
/*
  APB and output checks on ioa_core.
  Assumes the master holds requests until pready.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ioa_defines.svh"
module ioa_core_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic output_line_zero
);
  logic go_wr;
  assign go_wr = psel && penable && pready && pwrite
    && paddr == `IOA_OFF_CTRL && pwdata[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_cause: assert property (pready |-> psel && penable && $past(psel))
    else $error("pready without access");
  a_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error answer");
  a_data_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata outside answer");
  a_unmapped_err: assert property (pready && paddr > 8'h1c |-> pslverr)
    else $error("unmapped accepted");
  a_go_reads_zero: assert property
    (pready && !pwrite && paddr == `IOA_OFF_CTRL |-> !prdata[0])
    else $error("go bit read back");
  // Go taken at E, execute edge E+1, change seen sampled at E+2
  a_out_after_go: assert property
    ($changed(output_line_zero) |-> $past(go_wr, 2))
    else $error("output moved without command");
  c_err: cover property (pslverr);
  c_go: cover property (go_wr);
  c_out: cover property ($rose(output_line_zero));
endmodule
`default_nettype wire

// >>> testbench/io_read_accumulator_compare_bench.sv
/*
  Self-checking bench of ioa_core over APB.
  Assumes the pin model drives the input side.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ioa_defines.svh"
module io_read_accumulator_compare_bench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, rv;
  logic pready, pslverr, output_line_zero, er;
  logic in0, in1, in2;
  logic [11:0] ana;
  logic [15:0] sup, tmp;
  logic [2:0] pat = 3'b011;
  int n_mismatch = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  ioa_pin_model u_pins (.pattern(pat), .input_line_zero(in0),
    .input_line_one(in1), .input_line_two(in2), .analog_line_zero(ana),
    .supply_tenths(sup), .temperature_c(tmp));
  ioa_core u_dut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_line_zero(in0), .input_line_one(in1), .input_line_two(in2),
    .analog_line_zero(ana), .supply_tenths(sup), .temperature_c(tmp),
    .output_line_zero(output_line_zero));
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // One operation and one operand per frame, value bytes MSB first
  task automatic cmd(input logic [7:0] op, ty, bk, input logic [31:0] v,
    input logic sa, input logic [7:0] st);
    logic [7:0] s;
    int n;
    s = 8'h01 + op + ty + bk + v[31:24] + v[23:16] + v[15:8] + v[7:0];
    apb(1'b1, `IOA_OFF_STATUS, 32'h1);
    apb(1'b1, `IOA_OFF_VALUE, v);
    apb(1'b1, `IOA_OFF_CMD, {st == `IOA_ST_BAD_SUM ? ~s : s, bk, ty, op});
    apb(1'b1, `IOA_OFF_CTRL, {16'h0002, 8'h01, 6'h0, sa, 1'b1});
    n = 0;
    do
    begin
      apb(1'b0, `IOA_OFF_STATUS, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b1 && n < 10);
    chk("done", 32'h1, {31'h0, rd[0]});
    apb(1'b0, `IOA_OFF_RPL_HDR, 32'h0);
    chk("reply header", {16'h0201, st, op}, rd);
    s = rd[31:24] + rd[23:16] + rd[15:8] + rd[7:0];
    apb(1'b0, `IOA_OFF_RPL_VAL, 32'h0);
    rv = rd;
    s = s + rd[31:24] + rd[23:16] + rd[15:8] + rd[7:0];
    apb(1'b0, `IOA_OFF_RPL_SUM, 32'h0);
    chk("reply sum", {24'h0, s}, rd);
  endtask
  task automatic t_regs();
    apb(1'b0, `IOA_OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h00020100, rd);
    apb(1'b0, `IOA_OFF_ACC, 32'h0);
    chk("acc reset", 32'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    cmd(8'h0f, 8'h00, 8'h00, 32'h0, 1'b0, `IOA_ST_BAD_SUM);
    cmd(8'h13, 8'h03, 8'h00, 32'h0, 1'b0, `IOA_ST_BAD_VAL);
    apb(1'b0, `IOA_OFF_ACC, 32'h0);
    chk("acc after error", 32'h0, rd);
    cmd(8'h0f, 8'h05, 8'h01, 32'h0, 1'b0, `IOA_ST_BAD_TYPE);
    cmd(8'h30, 8'h00, 8'h00, 32'h0, 1'b0, `IOA_ST_BAD_CMD);
  endtask
  task automatic t_read_io();
    for (int p = 0; p < 3; p++)
    begin
      cmd(8'h0f, p[7:0], 8'h00, 32'h0, 1'b0, `IOA_ST_OK);
      chk("digital line", {31'h0, pat[p]}, rv);
    end
    cmd(8'h0f, `IOA_PORT_ALL, 8'h00, 32'h0, 1'b0, `IOA_ST_OK);
    apb(1'b0, `IOA_OFF_ACC, 32'h0);
    chk("input vector", 32'h3, rd);
    cmd(8'h0f, 8'h00, 8'h01, 32'h0, 1'b0, `IOA_ST_OK);
    chk("analog", 32'd302, rv);
    cmd(8'h0f, 8'h08, 8'h01, 32'h0, 1'b0, `IOA_ST_OK);
    chk("supply", 32'd240, rv);
    cmd(8'h0f, 8'h09, 8'h01, 32'h0, 1'b0, `IOA_ST_OK);
    chk("temperature", -32'sd5, rv);
    apb(1'b0, `IOA_OFF_ACC, 32'h0);
    chk("acc direct", 32'h3, rd);
    cmd(8'h0f, 8'h00, 8'h01, 32'h0, 1'b1, `IOA_ST_OK);
    apb(1'b0, `IOA_OFF_ACC, 32'h0);
    chk("acc standalone", 32'd302, rd);
  endtask
  task automatic t_accumulate_cmd_a();
    int ty[10] = '{9, 0, 1, 2, 3, 4, 5, 6, 7, 8};
    int v[10] = '{100, 7, 10, -3, 4, 5, 255, 256, 3, 0};
    int a;
    a = 0;
    for (int i = 0; i < 10; i++)
    begin
      case (ty[i])
        0: a = a + v[i];
        1: a = a - v[i];
        2: a = a * v[i];
        3: a = a / v[i];
        4: a = a % v[i];
        5: a = a & v[i];
        6: a = a | v[i];
        7: a = a ^ v[i];
        8: a = ~a;
        default: a = v[i];
      endcase
      cmd(8'h13, ty[i][7:0], 8'h00, v[i], 1'b0, `IOA_ST_OK);
      apb(1'b0, `IOA_OFF_ACC, 32'h0);
      chk("accumulate_cmd_a acc", a, rd);
    end
  endtask
  task automatic t_compare();
    int v[3] = '{-510, 0, -600};
    logic lt, gt, eq;
    logic [7:0] jx;
    for (int i = 0; i < 3; i++)
    begin
      lt = -510 < v[i];
      gt = -510 > v[i];
      eq = -510 == v[i];
      // Conditions 7..0: le, lt, ge, gt, ne, eq, nz, ze
      jx = {!gt, lt, !lt, gt, !eq, eq, !eq, eq};
      cmd(8'h14, 8'h33, 8'h44, v[i], 1'b1, `IOA_ST_OK);
      apb(1'b0, `IOA_OFF_STATUS, 32'h0);
      chk("flags", {lt, gt, eq, eq}, rd[11:8]);
      apb(1'b0, `IOA_OFF_ACC, 32'h0);
      chk("acc kept", -32'sd510, rd);
      for (int c = 0; c < 8; c++)
      begin
        cmd(8'h15, c[7:0], 8'h00, 32'h0, 1'b1, `IOA_ST_OK);
        chk("jump", {31'h0, jx[c]}, rv);
      end
    end
  endtask
  task automatic t_output();
    cmd(8'h0e, 8'h00, 8'h02, 32'h1, 1'b0, `IOA_ST_OK);
    chk("output pin", 32'h1, {31'h0, output_line_zero});
    cmd(8'h0f, 8'h00, 8'h02, 32'h0, 1'b0, `IOA_ST_OK);
    chk("output read", 32'h1, rv);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_read_io();
    t_accumulate_cmd_a();
    t_compare();
    t_output();
    print_verdict();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
bind ioa_core ioa_core_sva u_sva (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .output_line_zero(output_line_zero));
`default_nettype wire
